// file: aomadd_defines.svh
`ifndef AOMADD_DEFINES_SVH
`define AOMADD_DEFINES_SVH

// ==========================================================================
// Datapath widths
`define AOMADD_WORD_W        12
`define AOMADD_BUFFER_W      24
`define AOMADD_IR_FIELD_LSB  6
`define AOMADD_APB_ADDR_W    12

// ==========================================================================
// Register offsets (byte addresses)
`define AOMADD_CTRL_OFFSET   12'h000
`define AOMADD_RESULT_OFFSET 12'h004

// ==========================================================================
// Control register layout
`define AOMADD_CTRL_OVERRIDE_BIT 0
`define AOMADD_CTRL_FIELD_LSB    1
`define AOMADD_CTRL_FIELD_MSB    10
`define AOMADD_CTRL_RESET        32'h0000_0460

// ==========================================================================
// Result register layout
`define AOMADD_RES_SUM_LSB    0
`define AOMADD_RES_SUM_MSB    11
`define AOMADD_RES_RET_LSB    12
`define AOMADD_RES_RET_MSB    23
`define AOMADD_RES_CARRY_BIT  24
`define AOMADD_RES_ZERO_BIT   25

`endif

// file: aomadd_pkg.sv
`include "aomadd_defines.svh"

package aomadd_pkg;

  // ========================================================================
  // Select encodings
  typedef enum logic [1:0] {
    AOMADD_SOP_MEMORY_DATA = 2'h0,
    AOMADD_SOP_INSTR_FIELD = 2'h1,
    AOMADD_SOP_ACC_B       = 2'h2,
    AOMADD_SOP_ACC_A       = 2'h3
  } aomadd_sop_sel_t;

  typedef enum logic [2:0] {
    AOMADD_FOP_ADDRESS  = 3'h0,
    AOMADD_FOP_UTILITY  = 3'h1,
    AOMADD_FOP_PROGRAM  = 3'h2,
    AOMADD_FOP_EXT_B    = 3'h3,
    AOMADD_FOP_ACC_A    = 3'h4,
    AOMADD_FOP_ACC_B    = 3'h5,
    AOMADD_FOP_EXT_A    = 3'h6,
    AOMADD_FOP_STATUS   = 3'h7
  } aomadd_fop_sel_t;

  typedef enum logic [1:0] {
    AOMADD_UTIL_SWITCH     = 2'h0,
    AOMADD_UTIL_PERIPHERAL = 2'h1,
    AOMADD_UTIL_LIT_ACC_A  = 2'h2,
    AOMADD_UTIL_LIT_ACC_B  = 2'h3
  } aomadd_util_sel_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic first_operand_enable_n;
    logic first_operand_select_2;
    logic first_operand_select_1;
    logic first_operand_select_0;
    logic operand_invert_n;
    logic operand_true_n;
    logic second_operand_select_hi;
    logic second_operand_select_lo;
    logic buffer_half_select_n;
    logic return_sum_select_n;
  } aomadd_ctrl_t;

  typedef struct packed {
    logic [`AOMADD_BUFFER_W-1:0] buffer_word;
    logic [`AOMADD_WORD_W-1:0]   memory_data;
    logic [`AOMADD_WORD_W-1:0]   instr_reg;
    logic [`AOMADD_WORD_W-1:0]   acc_a;
    logic [`AOMADD_WORD_W-1:0]   acc_b;
    logic [`AOMADD_WORD_W-1:0]   ext_a;
    logic [`AOMADD_WORD_W-1:0]   ext_b;
    logic [`AOMADD_WORD_W-1:0]   address_reg;
    logic [`AOMADD_WORD_W-1:0]   program_counter;
  } aomadd_src_t;

  typedef struct packed {
    aomadd_util_sel_t          utility_source;
    logic [`AOMADD_WORD_W-1:0] switch_register;
    logic [`AOMADD_WORD_W-1:0] peripheral_data;
    logic [`AOMADD_WORD_W-1:0] literal_word;
  } aomadd_util_t;

  typedef struct packed {
    logic [`AOMADD_WORD_W-1:0] memory_return_bus;
    logic [`AOMADD_WORD_W-1:0] sum_bus;
    logic                      top_carry;
    logic                      sum_zero;
  } aomadd_res_t;

  typedef struct packed {
    aomadd_res_t  res;
    aomadd_ctrl_t sw_ctrl;
    logic         sw_override;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } aomadd_state_t;

endpackage

// file: aomadd_ripple.sv
`timescale 1ns/100ps
`include "aomadd_defines.svh"

module aomadd_ripple import aomadd_pkg::*; #(
  parameter int WIDTH = `AOMADD_WORD_W
) (
  // Operands
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  input  wire logic             carry_in,
  // Results
  output logic [WIDTH-1:0]      sum,
  output logic [WIDTH-1:0]      sum_n,
  output logic                  carry_out
);

  logic [WIDTH:0] carry;

  assign carry[0] = carry_in;

  // ========================================================================
  // Full-adder stages, carry rippling upward
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_stage
      assign sum[i]     = a[i] ^ b[i] ^ carry[i];
      assign carry[i+1] = (a[i] & b[i]) | (b[i] & carry[i]) | (a[i] & carry[i]);
      assign sum_n[i]   = ~sum[i];
    end
  endgenerate

  assign carry_out = carry[WIDTH];

endmodule // aomadd_ripple

// file: aomadd_core.sv
// Behaviour
// - Return-select low: memory return bus carries the adder sum.
// - Return-select high: upper buffer half if half-select low, else lower half.
// - Memory return bus feeds both memory data and instruction registers.
// - Second operand: 00 memory data, 01 instruction field, 10 acc B, 11 acc A.
// - Undriven second-operand selects default low, choosing memory data.
// - Add passes the selected word; subtract passes its bitwise complement.
// - Neither add nor subtract: second operand is all zeros, first passes through.
// - Subtract sets adder carry-in for two's complement result.
// - First operand: address, utility, program counter, ext B, acc A, acc B, ext A, status.
// - First operand passes only while enable low; no selects means address register.
// - First-operand enable high forces the first operand to zero.
// - Adder is a 12-bit ripple-carry binary full adder.
// - Sum goes on the sum bus for the accumulators, output, counters and return mux.
// - Inverted sum bits flag when all twelve stages are zero.
// - Carry out of the top stage goes to the overflow logic.
// - Utility word: switch register, peripheral data, or literal ANDed with acc A or B.
// - Status word gathers one-bit flags into one word for the first operand.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "aomadd_defines.svh"

module aomadd_core import aomadd_pkg::*; #(
  parameter int ADDR_W = `AOMADD_APB_ADDR_W
) (
  // Clock, reset and freeze
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      clk_en,
  // APB slave
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Select and command lines from the processor control logic
  input  wire aomadd_ctrl_t              ctrl,
  // Operand sources
  input  wire aomadd_src_t               src,
  input  wire aomadd_util_t              util,
  input  wire logic [`AOMADD_WORD_W-1:0] status_flags,
  // Results
  output aomadd_res_t                    res
);

  localparam logic [ADDR_W-1:0] CTRL_ADDR   = ADDR_W'(`AOMADD_CTRL_OFFSET);
  localparam logic [ADDR_W-1:0] RESULT_ADDR = ADDR_W'(`AOMADD_RESULT_OFFSET);
  localparam logic [31:0]       CTRL_RESET  = `AOMADD_CTRL_RESET;

  localparam aomadd_state_t STATE_RESET = '{
    res:         '0,
    sw_ctrl:     aomadd_ctrl_t'(CTRL_RESET[`AOMADD_CTRL_FIELD_MSB:`AOMADD_CTRL_FIELD_LSB]),
    sw_override: CTRL_RESET[`AOMADD_CTRL_OVERRIDE_BIT],
    prdata:      '0,
    pready:      1'b0,
    pslverr:     1'b0
  };

  aomadd_state_t             state;
  aomadd_state_t             next_state;
  aomadd_ctrl_t              eff;
  aomadd_sop_sel_t           sop_sel;
  aomadd_fop_sel_t           fop_sel;
  logic [`AOMADD_WORD_W-1:0] utility_inputs;
  logic [`AOMADD_WORD_W-1:0] status_word;
  logic [`AOMADD_WORD_W-1:0] sop_word;
  logic [`AOMADD_WORD_W-1:0] second_operand_mux;
  logic [`AOMADD_WORD_W-1:0] first_operand_mux;
  logic                      carry_in;
  logic [`AOMADD_WORD_W-1:0] sum;
  logic [`AOMADD_WORD_W-1:0] sum_n;
  logic                      top_carry;
  logic [`AOMADD_WORD_W-1:0] memory_return_bus;
  logic                      setup;
  logic                      access;
  logic                      hit_ctrl;
  logic                      hit_result;
  logic [31:0]               ctrl_read;
  logic [31:0]               result_read;

  // ========================================================================
  // Control source
  // Software may take over the select lines for bring-up; the pins rule
  // otherwise, so the processor sequencer sees no extra latency.
  always_comb begin
    eff = state.sw_override ? state.sw_ctrl : ctrl;
  end

  // ========================================================================
  // Utility gates and status assembly
  always_comb begin
    unique case (util.utility_source)
      AOMADD_UTIL_SWITCH:     utility_inputs = util.switch_register;
      AOMADD_UTIL_PERIPHERAL: utility_inputs = util.peripheral_data;
      AOMADD_UTIL_LIT_ACC_A:  utility_inputs = util.literal_word & src.acc_a;
      AOMADD_UTIL_LIT_ACC_B:  utility_inputs = util.literal_word & src.acc_b;
    endcase
  end

  // Flag layout is owned by the flag registers; this word only collects them
  genvar gi;
  generate
    for (gi = 0; gi < `AOMADD_WORD_W; gi++) begin : g_status
      assign status_word[gi] = status_flags[gi];
    end
  endgenerate

  // ========================================================================
  // Second-operand multiplexer with add/subtract gating
  always_comb begin
    // Undriven selects are pulled low by the sequencer, giving memory data
    sop_sel = aomadd_sop_sel_t'({eff.second_operand_select_hi, eff.second_operand_select_lo});
    unique case (sop_sel)
      AOMADD_SOP_MEMORY_DATA: sop_word = src.memory_data;
      AOMADD_SOP_INSTR_FIELD: sop_word = {src.instr_reg[`AOMADD_WORD_W-1:`AOMADD_IR_FIELD_LSB],
                                          {`AOMADD_IR_FIELD_LSB{1'b0}}};
      AOMADD_SOP_ACC_B:       sop_word = src.acc_b;
      AOMADD_SOP_ACC_A:       sop_word = src.acc_a;
    endcase
    // Subtract wins if both commands are asserted, keeping carry-in consistent
    if (!eff.operand_invert_n) begin
      second_operand_mux = ~sop_word;
    end else if (!eff.operand_true_n) begin
      second_operand_mux = sop_word;
    end else begin
      second_operand_mux = '0;
    end
    carry_in = ~eff.operand_invert_n;
  end

  // ========================================================================
  // First-operand multiplexer
  always_comb begin
    fop_sel = aomadd_fop_sel_t'({eff.first_operand_select_2, eff.first_operand_select_1,
                                 eff.first_operand_select_0});
    if (eff.first_operand_enable_n) begin
      first_operand_mux = '0;
    end else begin
      unique case (fop_sel)
        AOMADD_FOP_ADDRESS: first_operand_mux = src.address_reg;
        AOMADD_FOP_UTILITY: first_operand_mux = utility_inputs;
        AOMADD_FOP_PROGRAM: first_operand_mux = src.program_counter;
        AOMADD_FOP_EXT_B:   first_operand_mux = src.ext_b;
        AOMADD_FOP_ACC_A:   first_operand_mux = src.acc_a;
        AOMADD_FOP_ACC_B:   first_operand_mux = src.acc_b;
        AOMADD_FOP_EXT_A:   first_operand_mux = src.ext_a;
        AOMADD_FOP_STATUS:  first_operand_mux = status_word;
      endcase
    end
  end

  // ========================================================================
  // Adder
  aomadd_ripple #(
    .WIDTH (`AOMADD_WORD_W)
  ) u_adder (
    .a         (first_operand_mux),
    .b         (second_operand_mux),
    .carry_in  (carry_in),
    .sum       (sum),
    .sum_n     (sum_n),
    .carry_out (top_carry)
  );

  // ========================================================================
  // Memory return multiplexer
  always_comb begin
    if (!eff.return_sum_select_n) begin
      memory_return_bus = sum;
    end else if (!eff.buffer_half_select_n) begin
      memory_return_bus = src.buffer_word[`AOMADD_BUFFER_W-1:`AOMADD_WORD_W];
    end else begin
      memory_return_bus = src.buffer_word[`AOMADD_WORD_W-1:0];
    end
  end

  // ========================================================================
  // APB decode and read words
  always_comb begin
    setup      = psel & ~penable;
    access     = psel & penable & state.pready;
    hit_ctrl   = (paddr == CTRL_ADDR);
    hit_result = (paddr == RESULT_ADDR);
    ctrl_read  = '0;
    ctrl_read[`AOMADD_CTRL_FIELD_MSB:`AOMADD_CTRL_FIELD_LSB] = state.sw_ctrl;
    ctrl_read[`AOMADD_CTRL_OVERRIDE_BIT] = state.sw_override;
    result_read = '0;
    result_read[`AOMADD_RES_SUM_MSB:`AOMADD_RES_SUM_LSB] = state.res.sum_bus;
    result_read[`AOMADD_RES_RET_MSB:`AOMADD_RES_RET_LSB] = state.res.memory_return_bus;
    result_read[`AOMADD_RES_CARRY_BIT] = state.res.top_carry;
    result_read[`AOMADD_RES_ZERO_BIT]  = state.res.sum_zero;
  end

  // ========================================================================
  // Next state
  always_comb begin
    next_state = state;
    if (clk_en) begin
      // Results are latched so every output leaves a flip-flop
      next_state.res.sum_bus           = sum;
      next_state.res.memory_return_bus = memory_return_bus;
      next_state.res.top_carry         = top_carry;
      next_state.res.sum_zero          = &sum_n;
      // Answer is prepared in setup so access finishes in one cycle
      next_state.pready  = setup;
      next_state.pslverr = setup & ~(hit_ctrl | hit_result);
      if (setup && !pwrite) begin
        if (hit_ctrl) begin
          next_state.prdata = ctrl_read;
        end else if (hit_result) begin
          next_state.prdata = result_read;
        end else begin
          next_state.prdata = '0;
        end
      end
      // Result register is read-only; writes to it are dropped quietly
      if (access && pwrite && hit_ctrl) begin
        next_state.sw_ctrl     = aomadd_ctrl_t'(pwdata[`AOMADD_CTRL_FIELD_MSB:`AOMADD_CTRL_FIELD_LSB]);
        next_state.sw_override = pwdata[`AOMADD_CTRL_OVERRIDE_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;
  assign res     = state.res;

endmodule // aomadd_core

// file: aomadd_core_properties.sv
`timescale 1ns/100ps
module aomadd_props import aomadd_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  // APB
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Datapath
  input wire aomadd_ctrl_t      ctrl,
  input wire aomadd_src_t       src,
  input wire aomadd_res_t       res
);
  logic [10:0]  cq;
  aomadd_ctrl_t c;
  logic [11:0]  hi;
  assign hi = src.buffer_word[23:12];
  // Shadow of the control register, so overridden selects are judged too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cq <= 11'h460;
    else if (clk_en && psel && penable && pready && pwrite && paddr == 0) cq <= pwdata[10:0];
  end
  assign c = cq[0] ? aomadd_ctrl_t'(cq[10:1]) : ctrl;
  wire       en_n = c.first_operand_enable_n;
  wire [2:0] fop  = {c.first_operand_select_2, c.first_operand_select_1, c.first_operand_select_0};
  wire [1:0] sop  = {c.second_operand_select_hi, c.second_operand_select_lo};
  wire       ad_n = c.operand_true_n;
  wire       sb_n = c.operand_invert_n;
  // Attempts begun on the release edge would judge reset values; wait one edge
  logic      armed;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) armed <= 1'b0;
    else armed <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !armed);
  // ==========
  // Datapath and APB answer
  ret_sum_a: assert property (clk_en && !c.return_sum_select_n
    |=> res.memory_return_bus == res.sum_bus) else $error("return bus not sum");
  ret_upper_a: assert property (clk_en && c.return_sum_select_n && !c.buffer_half_select_n
    |=> res.memory_return_bus == $past(hi)) else $error("upper half not returned");
  pass_thru_a: assert property (clk_en && !en_n && fop == 3'h0 && ad_n && sb_n
    |=> res.sum_bus == $past(src.address_reg) && !res.top_carry) else $error("feed-through wrong");
  mux_off_a: assert property (clk_en && en_n && !ad_n && sb_n && sop == 2'h0
    |=> {res.top_carry, res.sum_bus} == {1'b0, $past(src.memory_data)}) else $error("first operand not zero");
  sub_ones_a: assert property (clk_en && en_n && !sb_n && sop == 2'h2
    |=> res.sum_bus == 12'h000 - $past(src.acc_b) && res.top_carry == ($past(src.acc_b) == 12'h000))
    else $error("subtract wrong");
  add_acc_a: assert property (clk_en && !en_n && fop == 3'h4 && sop == 2'h2 && !ad_n && sb_n
    |=> {res.top_carry, res.sum_bus} == {1'b0, $past(src.acc_a)} + {1'b0, $past(src.acc_b)})
    else $error("sum or carry wrong");
  zero_flag_a: assert property (clk_en |=> res.sum_zero == (res.sum_bus == 12'h000))
    else $error("zero flag wrong");
  apb_answer_a: assert property (psel && !penable && clk_en
    |=> pready && pslverr == (paddr != 12'h000 && paddr != 12'h004)) else $error("apb answer wrong");
  cover property (clk_en && !sb_n && !ad_n);
  cover property (pready && pslverr);
  cover property (clk_en && c.return_sum_select_n && c.buffer_half_select_n);
endmodule // aomadd_props

bind aomadd_core aomadd_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .ctrl(ctrl), .src(src), .res(res));

// file: aomadd_ctl_model.sv
`timescale 1ns/100ps
module aomadd_ctl_model import aomadd_pkg::*; (
  // Clock and directed values
  input  wire logic         pclk,
  input  wire logic         directed,
  input  wire aomadd_ctrl_t want_ctrl,
  input  wire aomadd_src_t  want_src,
  // Toward the datapath
  output aomadd_ctrl_t      ctrl,
  output aomadd_src_t       src,
  output aomadd_util_t      util,
  output logic [11:0]       status_flags
);
  logic [127:0] r;
  initial {ctrl, src, util, status_flags} = '0;
  // Fresh selects and operands every cycle; the bench can pin ctrl and src, never util or status_flags
  always @(posedge pclk) begin
    r = {$urandom(), $urandom(), $urandom(), $urandom()};
    util <= r[37:0];
    status_flags <= r[49:38];
    ctrl <= directed ? want_ctrl : aomadd_ctrl_t'(r[59:50]);
    r = {$urandom(), $urandom(), $urandom(), $urandom()};
    src <= directed ? want_src : aomadd_src_t'(r[119:0]);
  end
endmodule // aomadd_ctl_model

// file: test_arithmetic_operand_mux_adder.sv
`timescale 1ns/100ps
module test_arithmetic_operand_mux_adder import aomadd_pkg::*;;
  logic         pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, directed = 0;
  logic [11:0]  paddr = '0, flags;
  logic [31:0]  pwdata = '0, prdata, rd;
  logic         pready, pslverr, er;
  logic [10:0]  shadow = 11'h460;
  aomadd_ctrl_t ctrl, wc = '0;
  aomadd_src_t  src, ws = '0;
  aomadd_util_t util;
  aomadd_res_t  res, exp_res;
  int           miscompares = 0, n_compared = 0;
  logic [9:0]   cc [4] = '{10'h218, 10'h021, 10'h0f3, 10'h10c};
  logic [24:0]  ce [4] = '{{13'h1000, 12'h000}, {13'h1000, 12'habc}, {13'h05a5, 12'h123}, {13'h1000, 12'h000}};

  always #50 pclk = ~pclk;

  aomadd_ctl_model partner (.pclk(pclk), .directed(directed), .want_ctrl(wc), .want_src(ws), .ctrl(ctrl),
    .src(src), .util(util), .status_flags(flags));
  aomadd_core DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl(ctrl), .src(src), .util(util), .status_flags(flags), .res(res));

  // ==========
  // Reference model
  function automatic aomadd_res_t calc(aomadd_ctrl_t c, aomadd_src_t s, aomadd_util_t u, logic [11:0] f);
    logic [1:0]  us = u.utility_source;
    logic [11:0] tv [4];
    logic [11:0] mv [8];
    logic [11:0] m, w;
    logic [12:0] r;
    tv = '{s.memory_data, {s.instr_reg[11:6], 6'h00}, s.acc_b, s.acc_a};
    w = us[1] ? u.literal_word & (us[0] ? s.acc_b : s.acc_a) : (us[0] ? u.peripheral_data : u.switch_register);
    mv = '{s.address_reg, w, s.program_counter, s.ext_b, s.acc_a, s.acc_b, s.ext_a, f};
    m = c.first_operand_enable_n ? 12'h000
      : mv[{c.first_operand_select_2, c.first_operand_select_1, c.first_operand_select_0}];
    w = tv[{c.second_operand_select_hi, c.second_operand_select_lo}];
    r = !c.operand_invert_n ? {1'b0, m} + {1'b0, ~w} + 13'h0001
      : {1'b0, m} + (c.operand_true_n ? 13'h0000 : {1'b0, w});
    return '{!c.return_sum_select_n ? r[11:0] : c.buffer_half_select_n ? s.buffer_word[11:0]
      : s.buffer_word[23:12], r[11:0], r[12], r[11:0] == 12'h000};
  endfunction

  task check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, want, seen);
    end
  endtask

  task wrap_up;
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check("pready", pready, 1);
    rd = prdata;
    er = pslverr;
    if (w && a == 0 && er === 1'b0) shadow <= d[10:0];
    psel <= 0;
    penable <= 0;
  endtask

  // Results land one edge after the operands; compare every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_res <= '0;
      shadow <= 11'h460;
    end else if (clk_en) exp_res <= calc(shadow[0] ? aomadd_ctrl_t'(shadow[10:1]) : ctrl, src, util, flags);
  end
  always @(negedge pclk) if (presetn) check("res", res, exp_res);

  initial begin
    #2000000;
    miscompares++;
    wrap_up;
  end

  initial begin
    void'($urandom(51));
    ws.memory_data = 12'h001;
    ws.acc_a = 12'h7ff;
    ws.ext_b = 12'h5a5;
    ws.address_reg = 12'hfff;
    ws.buffer_word = 24'habc123;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    check("ctrl reset", rd[10:0], 11'h460);
    repeat (3000) begin
      @(posedge pclk);
      clk_en <= $urandom_range(7) != 0;
    end
    @(posedge pclk);
    clk_en <= 1;
    directed <= 1;
    foreach (cc[i]) begin
      wc <= cc[i];
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check("corner", {res.top_carry, res.sum_bus, res.memory_return_bus}, ce[i]);
    end
    apb(1, 12'h004, 32'hffff_ffff);
    check("result write err", er, 0);
    apb(0, 12'h004, 0);
    check("result", rd, {6'h00, exp_res.sum_zero, exp_res.top_carry, exp_res.memory_return_bus, exp_res.sum_bus});
    apb(1, 12'h010, 32'h0000_0001);
    apb(0, 12'h010, 0);
    check("unmapped err", er, 1);
    check("unmapped data", rd, 0);
    directed <= 0;
    // Register fields take over the select lines
    repeat (40) begin
      apb(1, 12'h000, ($urandom_range(1023) << 1) | 32'h1);
      repeat (20) @(posedge pclk);
    end
    apb(0, 12'h000, 0);
    check("ctrl readback", rd[10:0], shadow);
    @(posedge pclk);
    presetn <= 0;
    @(negedge pclk);
    check("res in reset", res, 0);
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    check("ctrl after reset", rd[10:0], 11'h460);
    repeat (10) @(posedge pclk);
    wrap_up;
  end
endmodule // test_arithmetic_operand_mux_adder
